// ===== rsc_regs.sv
// Radio sync pattern, signal strength and transmit front-end register bank
//
// Notes on behaviour
// - Signal strength: signed 8-bit dB, resets zero
// - Strength averaged over last 8 symbols
// - Sync pattern used nibble by nibble, LSN first
// - Pattern bytes reset A7 and 0F, read-write
// - Transmit sends zero for each F nibble
// - Receive treats F nibbles as wildcards
// - Receive needs zero symbol before first nibble
// - Start delay 128 or 192 us, select resets 1
// - Amp output differential bit, resets 1
// - Amp current trim, 3 bits, resets 011
// - Amp level bits 4:0, resets 1F
// - TX mixer buffer bias 7:6, resets 10
// - TX varactor and mixer bias reset zero
// - RX bias bits 7:6 read zero
// - RX mixer buffer bias 5:4, resets 01
// - High-gain compensation 3:2, resets 00
// - Medium-gain compensation 1:0, resets 10
// - Channel clear when strength below threshold
`timescale 1ns/1ps

module rsc_regs (
	input  wire logic                     ref_clk,
	input  wire logic                     srst,
	input  wire rsc_pkg::rsc_bus_req_t    bus_req,
	output logic [7:0]                    bus_rdata,
	input  wire logic signed [7:0]        rx_power_sample,
	input  wire logic                     rx_sample_valid,
	input  wire logic                     rx_symbol_valid,
	input  wire logic [3:0]               rx_symbol,
	input  wire logic                     transmit_on_strobe,
	output logic                          frame_sync_found,
	output logic                          tx_symbol_valid,
	output logic [3:0]                    tx_symbol,
	output logic                          tx_sync_done,
	output logic                          channel_clear_indication,
	output rsc_pkg::rsc_analog_cfg_t      analog_cfg
);

	// ==========================================================
	// Input synchronisers (the radio side is not on ref_clk)
	logic [1:0] sync1_q;
	logic [1:0] sync2_q;
	logic       txon_prev_q;
	logic       txon_pulse;
	logic signed [7:0] power_s1_q;
	logic signed [7:0] power_s2_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
			txon_prev_q <= 1'b0;
		end else begin
			sync1_q <= {transmit_on_strobe, rx_sample_valid};
			sync2_q <= sync1_q;
			txon_prev_q <= sync2_q[1];
		end
	end

	// Previous level resets low, the idle level of the strobe pin, so no
	// false start follows a reset
	assign txon_pulse = sync2_q[1] & ~txon_prev_q;

	// Power word takes the same two stages as its valid flag, so the pair
	// stays aligned; the radio must hold the word steady around the flag
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			power_s1_q <= 8'sh00;
			power_s2_q <= 8'sh00;
		end else begin
			power_s1_q <= rx_power_sample;
			power_s2_q <= power_s1_q;
		end
	end

	// ==========================================================
	// Configuration registers
	logic [15:0] sync_pat_q;
	logic [7:0]  channel_clear_threshold_q;
	rsc_pkg::rsc_analog_cfg_t cfg_q;

	// Writes land at the edge that takes the strobe, so a read in the
	// very next cycle already returns the new value

	function automatic logic wr_hit(input rsc_pkg::rsc_bus_req_t r, input logic [15:0] a);
		wr_hit = r.wr && (r.addr == a);
	endfunction

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sync_pat_q <= {rsc_pkg::RST_SYNC_HI, rsc_pkg::RST_SYNC_LO};
			channel_clear_threshold_q  <= rsc_pkg::RST_CHANNEL_CLEAR_THRESHOLD;
		end else begin
			if (wr_hit(bus_req, rsc_pkg::ADDR_SYNC_HI)) begin
				sync_pat_q[15:8] <= bus_req.wdata;
			end
			if (wr_hit(bus_req, rsc_pkg::ADDR_SYNC_LO)) begin
				sync_pat_q[7:0] <= bus_req.wdata;
			end
			if (wr_hit(bus_req, rsc_pkg::ADDR_CHANNEL_CLEAR_THRESHOLD)) begin
				channel_clear_threshold_q <= bus_req.wdata;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cfg_q.tx_mixer_buffer_bias     <= rsc_pkg::RST_TXMIXBUF;
			cfg_q.tx_start_delay_select    <= rsc_pkg::RST_TURN;
			cfg_q.tx_mixer_varactor_select <= rsc_pkg::RST_TXCAP;
			cfg_q.tx_mixer_bias            <= rsc_pkg::RST_TXMIX;
			cfg_q.amp_output_differential  <= rsc_pkg::RST_PADIFF;
			cfg_q.amp_bias_trim            <= rsc_pkg::RST_PACUR;
			cfg_q.amp_output_level         <= rsc_pkg::RST_PALVL;
			cfg_q.rx_mixer_buffer_bias     <= rsc_pkg::RST_RXMIXBUF;
			cfg_q.comp_branch_high_gain    <= rsc_pkg::RST_HIGAIN;
			cfg_q.comp_branch_medium_gain  <= rsc_pkg::RST_MEDGAIN;
		end else begin
			if (wr_hit(bus_req, rsc_pkg::ADDR_TX_HI)) begin
				cfg_q.tx_mixer_buffer_bias <= bus_req.wdata[rsc_pkg::POS_TXMIXBUF +: 2];
				cfg_q.tx_start_delay_select <= bus_req.wdata[rsc_pkg::POS_TURN];
				cfg_q.tx_mixer_varactor_select <= bus_req.wdata[rsc_pkg::POS_TXCAP +: 2];
				cfg_q.tx_mixer_bias <= bus_req.wdata[rsc_pkg::POS_TXMIX +: 2];
				cfg_q.amp_output_differential <= bus_req.wdata[rsc_pkg::POS_PADIFF];
			end
			if (wr_hit(bus_req, rsc_pkg::ADDR_TX_LO)) begin
				cfg_q.amp_bias_trim <= bus_req.wdata[rsc_pkg::POS_PACUR +: 3];
				cfg_q.amp_output_level <= bus_req.wdata[rsc_pkg::POS_PALVL +: 5];
			end
			if (wr_hit(bus_req, rsc_pkg::ADDR_RXBIAS)) begin
				// Bits 7:6 are dropped here
				cfg_q.rx_mixer_buffer_bias <= bus_req.wdata[rsc_pkg::POS_RXMIXBUF +: 2];
				cfg_q.comp_branch_high_gain <= bus_req.wdata[rsc_pkg::POS_HIGAIN +: 2];
				cfg_q.comp_branch_medium_gain <= bus_req.wdata[rsc_pkg::POS_MEDGAIN +: 2];
			end
		end
	end

	assign analog_cfg = cfg_q;

	// ==========================================================
	// Signal strength: 8-symbol running average
	// Power samples run through their own two flops every cycle, alongside the
	// valid flag, and are summed while the synchronised flag is high.
	logic signed [7:0]  win_q [rsc_pkg::AVG_SYMS];
	logic signed [10:0] acc_q;
	logic signed [11:0] sym_sum_q;
	logic [9:0]         sym_cnt_q;
	logic [3:0]         sym_n_q;
	logic signed [7:0]  sym_avg;
	logic signed [7:0]  rssi_q;
	logic               sym_tick;

	// Last cycle of each symbol period
	assign sym_tick = (sym_cnt_q == 10'(rsc_pkg::SYM_CYC - 1));

	// Fifteen full-scale samples need twelve bits of sum
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sym_cnt_q <= 10'h000;
			sym_sum_q <= 12'sh000;
			sym_n_q   <= 4'h0;
		end else if (sym_tick) begin
			sym_cnt_q <= 10'h000;
			sym_sum_q <= 12'sh000;
			sym_n_q   <= 4'h0;
		end else begin
			sym_cnt_q <= sym_cnt_q + 10'h001;
			if (sync2_q[0] && sym_n_q != 4'hF) begin
				sym_sum_q <= sym_sum_q + 12'(power_s2_q);
				sym_n_q   <= sym_n_q + 4'h1;
			end
		end
	end

	// One value per symbol: mean of samples seen, or the last if none
	// The divider is large but only settles once per symbol, so timing
	// is relaxed; a reciprocal table was not worth the area
	assign sym_avg = (sym_n_q == 4'h0) ? win_q[0] :
		8'(sym_sum_q / $signed({8'h00, sym_n_q}));

	for (genvar i = 0; i < rsc_pkg::AVG_SYMS; i++) begin : g_win
		always_ff @(posedge ref_clk) begin
			if (srst) begin
				win_q[i] <= 8'sh00;
			end else if (sym_tick) begin
				win_q[i] <= (i == 0) ? sym_avg : win_q[(i == 0) ? 0 : i - 1];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			acc_q  <= 11'sh000;
			rssi_q <= rsc_pkg::RST_RSSI;
		end else begin
			if (sym_tick) begin
				acc_q <= acc_q + 11'(sym_avg)
					- 11'(win_q[rsc_pkg::AVG_SYMS - 1]);
			end
			rssi_q <= 8'(acc_q >>> rsc_pkg::AVG_SHIFT);
		end
	end

	// Both sides are signed; an unsigned compare would call every
	// negative reading busy
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			channel_clear_indication <= 1'b0;
		end else begin
			channel_clear_indication <= rssi_q < $signed(channel_clear_threshold_q);
		end
	end

	// ==========================================================
	// Register read port
	// Data stand for one cycle only, then fall back to zero, so a stale
	// value can never be mistaken for a fresh read
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			bus_rdata <= 8'h00;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				rsc_pkg::ADDR_RSSI:    bus_rdata <= rssi_q;
				rsc_pkg::ADDR_SYNC_HI: bus_rdata <= sync_pat_q[15:8];
				rsc_pkg::ADDR_SYNC_LO: bus_rdata <= sync_pat_q[7:0];
				rsc_pkg::ADDR_CHANNEL_CLEAR_THRESHOLD: bus_rdata <= channel_clear_threshold_q;
				rsc_pkg::ADDR_TX_HI:   bus_rdata <= {cfg_q.tx_mixer_buffer_bias,
					cfg_q.tx_start_delay_select, cfg_q.tx_mixer_varactor_select,
					cfg_q.tx_mixer_bias, cfg_q.amp_output_differential};
				rsc_pkg::ADDR_TX_LO:   bus_rdata <= {cfg_q.amp_bias_trim,
					cfg_q.amp_output_level};
				rsc_pkg::ADDR_RXBIAS:  bus_rdata <= {2'h0, cfg_q.rx_mixer_buffer_bias,
					cfg_q.comp_branch_high_gain,
					cfg_q.comp_branch_medium_gain};
				// Unmapped addresses read zero
				default:               bus_rdata <= 8'h00;
			endcase
		end else begin
			bus_rdata <= 8'h00;
		end
	end
	// No write path to rssi_q exists

	// ==========================================================
	// Transmit: start delay then sync pattern nibbles
	// The delay counts from the detected strobe edge, so the synchroniser
	// adds two cycles of latency (sync1_q, sync2_q) on top of the programmed wait.
	// Strobes arriving while a pattern is under way are ignored.
	rsc_pkg::rsc_tx_state_t tx_state_q;
	logic [12:0] tx_wait_q;
	logic [1:0]  tx_nib_q;
	logic [3:0]  tx_nib;

	assign tx_nib = sync_pat_q[{tx_nib_q, 2'b00} +: 4];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_state_q      <= rsc_pkg::TX_IDLE;
			tx_wait_q       <= 13'h0000;
			tx_nib_q        <= 2'h0;
			tx_symbol_valid <= 1'b0;
			tx_symbol       <= 4'h0;
			tx_sync_done    <= 1'b0;
		end else begin
			tx_symbol_valid <= 1'b0;
			tx_sync_done    <= 1'b0;
			case (tx_state_q)
				rsc_pkg::TX_IDLE: begin
					if (txon_pulse) begin
						tx_wait_q <= cfg_q.tx_start_delay_select ?
							13'(rsc_pkg::TURN_LONG_CYC - 1) :
							13'(rsc_pkg::TURN_SHORT_CYC - 1);
						tx_state_q <= rsc_pkg::TX_WAIT;
					end
				end
				rsc_pkg::TX_WAIT: begin
					if (tx_wait_q == 13'h0000) begin
						tx_nib_q   <= 2'h0;
						tx_wait_q  <= 13'(rsc_pkg::SYM_CYC - 1);
						tx_state_q <= rsc_pkg::TX_SYNC;
					end else begin
						tx_wait_q <= tx_wait_q - 13'h0001;
					end
				end
				rsc_pkg::TX_SYNC: begin
					if (tx_wait_q == 13'(rsc_pkg::SYM_CYC - 1)) begin
						tx_symbol_valid <= 1'b1;
						tx_symbol <= (tx_nib == rsc_pkg::NIB_WILD) ?
							rsc_pkg::NIB_ZERO : tx_nib;
					end
					if (tx_wait_q == 13'h0000) begin
						tx_wait_q <= 13'(rsc_pkg::SYM_CYC - 1);
						if (tx_nib_q == 2'(rsc_pkg::NIB_COUNT - 1)) begin
							tx_sync_done <= 1'b1;
							tx_state_q   <= rsc_pkg::TX_IDLE;
						end else begin
							tx_nib_q <= tx_nib_q + 2'h1;
						end
					end else begin
						tx_wait_q <= tx_wait_q - 13'h0001;
					end
				end
				default: tx_state_q <= rsc_pkg::TX_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Receive: sync search over the last five symbols
	// Leading F nibbles are skipped so the implicit zero sits just before
	// the first nibble that must match.
	logic [3:0] rx_hist_q [5];
	logic [2:0] rx_cnt_q;
	logic       rx_match;

	always_comb begin
		logic       started;
		logic [2:0] k;
		started  = 1'b0;
		k        = 3'h0;
		rx_match = 1'b1;
		for (int n = 0; n < rsc_pkg::NIB_COUNT; n++) begin
			if (sync_pat_q[n*4 +: 4] != rsc_pkg::NIB_WILD) begin
				if (!started) begin
					started = 1'b1;
					k = 3'(n);
					if (rx_hist_q[(n == 0) ? 4 : n - 1] != rsc_pkg::NIB_ZERO) begin
						rx_match = 1'b0;
					end
				end
				if (rx_hist_q[n] != sync_pat_q[n*4 +: 4]) begin
					rx_match = 1'b0;
				end
			end
		end
		if (rx_cnt_q < 3'(rsc_pkg::NIB_COUNT + 1) - k) begin
			rx_match = 1'b0;
		end
	end

	// rx_hist_q[0] is the oldest of the four pattern slots
	// Slot 4 holds the symbol received just before slot 0
	// Symbol count saturates so a long idle stream cannot wrap back
	// into the too-few-symbols window
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int j = 0; j < 5; j++) begin
				rx_hist_q[j] <= 4'h0;
			end
			rx_cnt_q         <= 3'h0;
			frame_sync_found <= 1'b0;
		end else begin
			frame_sync_found <= 1'b0;
			if (rx_symbol_valid) begin
				rx_hist_q[0] <= rx_hist_q[1];
				rx_hist_q[1] <= rx_hist_q[2];
				rx_hist_q[2] <= rx_hist_q[3];
				rx_hist_q[3] <= rx_symbol;
				rx_hist_q[4] <= rx_hist_q[0];
				if (rx_cnt_q != 3'h7) begin
					rx_cnt_q <= rx_cnt_q + 3'h1;
				end
			end else if (rx_match && rx_cnt_q != 3'h0) begin
				frame_sync_found <= 1'b1;
				rx_cnt_q <= 3'h0;
			end
		end
	end

endmodule

// ===== rsc_pkg.sv
// Package: register map, field layout and timing constants of the radio config bank
package rsc_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [15:0] ADDR_CHANNEL_CLEAR_THRESHOLD   = 16'hDF05;
	localparam logic [15:0] ADDR_RSSI      = 16'hDF07;
	localparam logic [15:0] ADDR_SYNC_HI   = 16'hDF08;
	localparam logic [15:0] ADDR_SYNC_LO   = 16'hDF09;
	localparam logic [15:0] ADDR_TX_HI     = 16'hDF0A;
	localparam logic [15:0] ADDR_TX_LO     = 16'hDF0B;
	localparam logic [15:0] ADDR_RXBIAS    = 16'hDF0C;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_RSSI    = 8'h00;
	localparam logic [7:0] RST_SYNC_HI = 8'hA7;
	localparam logic [7:0] RST_SYNC_LO = 8'h0F;
	localparam logic [7:0] RST_CHANNEL_CLEAR_THRESHOLD = 8'hE0;
	localparam logic [1:0] RST_TXMIXBUF = 2'h2;
	localparam logic       RST_TURN     = 1'b1;
	localparam logic [1:0] RST_TXCAP    = 2'h0;
	localparam logic [1:0] RST_TXMIX    = 2'h0;
	localparam logic       RST_PADIFF   = 1'b1;
	localparam logic [2:0] RST_PACUR    = 3'h3;
	localparam logic [4:0] RST_PALVL    = 5'h1F;
	localparam logic [1:0] RST_RXMIXBUF = 2'h1;
	localparam logic [1:0] RST_HIGAIN   = 2'h0;
	localparam logic [1:0] RST_MEDGAIN  = 2'h2;

	// ==========================================================
	// Field positions (low bit of each field)
	localparam int POS_TXMIXBUF = 6;
	localparam int POS_TURN     = 5;
	localparam int POS_TXCAP    = 3;
	localparam int POS_TXMIX    = 1;
	localparam int POS_PADIFF   = 0;
	localparam int POS_PACUR    = 5;
	localparam int POS_PALVL    = 0;
	localparam int POS_RXMIXBUF = 4;
	localparam int POS_HIGAIN   = 2;
	localparam int POS_MEDGAIN  = 0;

	// ==========================================================
	// Timing
	localparam int CLK_HZ        = 20_000_000;
	localparam int SYM_NS        = 16_000;
	localparam int SYM_CYC       = (SYM_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int AVG_SYMS      = 8;
	localparam int AVG_SHIFT     = 3;
	localparam int TURN_SHORT_US = 128;
	localparam int TURN_LONG_US  = 192;
	localparam int TURN_SHORT_CYC = TURN_SHORT_US * (CLK_HZ / 1_000_000);
	localparam int TURN_LONG_CYC  = TURN_LONG_US * (CLK_HZ / 1_000_000);
	localparam int NIB_COUNT     = 4;

	localparam logic [3:0] NIB_WILD = 4'hF;
	localparam logic [3:0] NIB_ZERO = 4'h0;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} rsc_bus_req_t;

	typedef struct packed {
		logic [1:0] tx_mixer_buffer_bias;
		logic       tx_start_delay_select;
		logic [1:0] tx_mixer_varactor_select;
		logic [1:0] tx_mixer_bias;
		logic       amp_output_differential;
		logic [2:0] amp_bias_trim;
		logic [4:0] amp_output_level;
		logic [1:0] rx_mixer_buffer_bias;
		logic [1:0] comp_branch_high_gain;
		logic [1:0] comp_branch_medium_gain;
	} rsc_analog_cfg_t;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b001,
		TX_WAIT  = 3'b010,
		TX_SYNC  = 3'b100
	} rsc_tx_state_t;

endpackage

// ===== rsc_regs_sva.sv
// Concurrent checks on the radio config bank ports
`timescale 1ns/1ps

module rsc_regs_chk (
	input wire logic                     ref_clk,
	input wire logic                     srst,
	input wire rsc_pkg::rsc_bus_req_t    bus_req,
	input wire logic [7:0]               bus_rdata,
	input wire logic                     rx_symbol_valid,
	input wire logic                     frame_sync_found,
	input wire logic                     tx_symbol_valid,
	input wire logic [3:0]               tx_symbol,
	input wire logic                     tx_sync_done,
	input wire rsc_pkg::rsc_analog_cfg_t analog_cfg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);

	// ==========
	// Register side
	resv_zero_a: assert property (
		$past(bus_req.rd && bus_req.addr == rsc_pkg::ADDR_RXBIAS) |-> bus_rdata[7:6] == 2'h0)
		else $error("reserved bias bits read nonzero");
	unmapped_rd_a: assert property (
		$past(bus_req.rd && bus_req.addr[15:8] != 8'hDF) |-> bus_rdata == 8'h00)
		else $error("unmapped read returned data");
	cfg_hold_a: assert property (
		!$past(bus_req.wr) && !$past(srst) |-> $stable(analog_cfg))
		else $error("analog config moved without a write");
	amp_write_a: assert property (
		$past(bus_req.wr && bus_req.addr == rsc_pkg::ADDR_TX_LO) |->
		{analog_cfg.amp_bias_trim, analog_cfg.amp_output_level} == $past(bus_req.wdata))
		else $error("amp fields differ from written byte");
	txfe_write_a: assert property (
		$past(bus_req.wr && bus_req.addr == rsc_pkg::ADDR_TX_HI) |->
		analog_cfg[21:14] == $past(bus_req.wdata))
		else $error("tx front end fields differ from written byte");
	rxfe_write_a: assert property (
		$past(bus_req.wr && bus_req.addr == rsc_pkg::ADDR_RXBIAS) |->
		analog_cfg[5:0] == $past(bus_req.wdata[5:0]))
		else $error("rx bias fields differ from written byte");

	// ==========
	// Sync pattern paths
	tx_no_wild_a: assert property (
		tx_symbol_valid |-> tx_symbol != rsc_pkg::NIB_WILD)
		else $error("wildcard nibble transmitted");
	tx_pulse_a: assert property (
		tx_symbol_valid |=> !tx_symbol_valid [*8])
		else $error("tx nibbles too close");
	tx_hold_a: assert property (
		!tx_symbol_valid |-> $stable(tx_symbol))
		else $error("tx nibble changed between strobes");
	sync_pulse_a: assert property (
		frame_sync_found |-> !$past(rx_symbol_valid) ##1 !frame_sync_found)
		else $error("sync found not a single gap pulse");

	cover property (frame_sync_found);
	cover property (tx_sync_done);
	cover property ($past(bus_req.wr && bus_req.addr == rsc_pkg::ADDR_RXBIAS));
endmodule

bind rsc_regs rsc_regs_chk rsc_regs_chk_i (.ref_clk, .srst, .bus_req, .bus_rdata,
	.rx_symbol_valid, .frame_sync_found, .tx_symbol_valid, .tx_symbol, .tx_sync_done,
	.analog_cfg);

// ===== rsc_regs_test.sv
// Self-checking bench for the radio config register bank
`timescale 1ns/1ps

module rsc_regs_test;
	typedef struct packed {
		logic [15:0] a;
		logic [7:0]  d;
		logic        w;
		logic [7:0]  e;
	} rsc_row_t;

	logic                     ref_clk = 1'b0;
	logic                     srst = 1'b1;
	rsc_pkg::rsc_bus_req_t    bus_req = '0;
	logic [7:0]               bus_rdata;
	logic signed [7:0]        rx_power_sample = 8'hEC;
	logic                     rx_sample_valid = 1'b0;
	logic                     rx_symbol_valid = 1'b0;
	logic [3:0]               rx_symbol = 4'h0;
	logic                     transmit_on_strobe = 1'b0;
	logic                     frame_sync_found;
	logic                     tx_symbol_valid;
	logic [3:0]               tx_symbol;
	logic                     tx_sync_done;
	logic                     channel_clear_indication;
	rsc_pkg::rsc_analog_cfg_t analog_cfg;
	int                       num_errors = 0;
	int                       comparisons = 0;
	int                       n;
	int                       d;
	logic                     seen;
	logic [7:0]               q;
	localparam logic [15:0]   TX_NIBS = 16'h1204;

	rsc_row_t rows [12] = '{
		'{rsc_pkg::ADDR_RSSI, 8'h00, 1'b0, 8'h00}, '{rsc_pkg::ADDR_SYNC_HI, 8'h00, 1'b0, 8'hA7},
		'{rsc_pkg::ADDR_SYNC_LO, 8'h00, 1'b0, 8'h0F}, '{rsc_pkg::ADDR_TX_HI, 8'h00, 1'b0, 8'hA1},
		'{rsc_pkg::ADDR_TX_LO, 8'h00, 1'b0, 8'h7F}, '{rsc_pkg::ADDR_RXBIAS, 8'h00, 1'b0, 8'h12},
		'{16'hDF00, 8'h00, 1'b0, 8'h00}, '{rsc_pkg::ADDR_SYNC_HI, 8'h5A, 1'b1, 8'h5A},
		'{rsc_pkg::ADDR_TX_HI, 8'h5E, 1'b1, 8'h5E}, '{rsc_pkg::ADDR_TX_LO, 8'h80, 1'b1, 8'h80},
		'{rsc_pkg::ADDR_RXBIAS, 8'hFF, 1'b1, 8'h3F}, '{rsc_pkg::ADDR_RSSI, 8'h55, 1'b1, 8'h00}};
	// Pattern high, pattern low, five nibbles newest first, sync expected
	logic [36:0] rxc [4] = '{{8'hA7, 8'h0E, 20'hA70E0, 1'b1}, {8'hA7, 8'h0E, 20'hA70E5, 1'b0},
		{8'hAF, 8'h0E, 20'hA90E0, 1'b1}, {8'hAF, 8'h0E, 20'hB90E0, 1'b0}};

	rsc_regs rsc_regs_i (.ref_clk, .srst, .bus_req, .bus_rdata, .rx_power_sample,
		.rx_sample_valid, .rx_symbol_valid, .rx_symbol, .transmit_on_strobe, .frame_sync_found,
		.tx_symbol_valid, .tx_symbol, .tx_sync_done, .channel_clear_indication, .analog_cfg);

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end

	// ==========
	// Bus and compare tasks
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		bus_req.addr <= a;
		bus_req.wdata <= v;
		bus_req.wr <= 1'b1;
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
		#1;
		v = bus_rdata;
	endtask

	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask

	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ==========
	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d);
			end
			rd(rows[i].a, q);
			chk8("register readback", rows[i].e, q);
		end
		$display("test register table done");
		// Reset in mid-run has to bring every written field back
		@(posedge ref_clk);
		srst <= 1'b1;
		@(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk_bit("analog cfg reset", 1'b1, analog_cfg === 22'b10_1_00_00_1_011_11111_01_00_10);
		rd(rsc_pkg::ADDR_SYNC_HI, q);
		chk8("pattern upper reset", 8'hA7, q);
		$display("test mid-run reset done");
		wr(rsc_pkg::ADDR_SYNC_HI, 8'h12);
		wr(rsc_pkg::ADDR_SYNC_LO, 8'hF4);
		for (int s = 0; s < 2; s++) begin
			wr(rsc_pkg::ADDR_TX_HI, (s != 0) ? 8'hA1 : 8'h81);
			d = (s != 0) ? rsc_pkg::TURN_LONG_CYC : rsc_pkg::TURN_SHORT_CYC;
			@(posedge ref_clk);
			transmit_on_strobe <= 1'b1;
			repeat (20) @(posedge ref_clk);
			transmit_on_strobe <= 1'b0;
			n = 20;
			while (tx_symbol_valid !== 1'b1 && n < 5000) begin
				@(posedge ref_clk);
				#1;
				n++;
			end
			// Strobe goes through a synchroniser, so allow a few cycles of slack
			chk_bit("tx start delay", 1'b1, n >= d + 1 && n <= d + 8);
			for (int k = 0; k < 4; k++) begin
				chk8("tx nibble", {4'h0, TX_NIBS[k*4 +: 4]}, {4'h0, tx_symbol});
				n = 0;
				while ((n == 0 || tx_symbol_valid !== 1'b1) && n < 1000 && k < 3) begin
					@(posedge ref_clk);
					#1;
					n++;
				end
				if (k < 3) begin
					chk_bit("tx nibble spacing", 1'b1, n == rsc_pkg::SYM_CYC);
				end
			end
			n = 0;
			while (tx_sync_done !== 1'b1 && n < 1000) begin
				@(posedge ref_clk);
				#1;
				n++;
			end
			chk_bit("tx sync done", 1'b1, tx_sync_done);
		end
		$display("test transmit done");
		foreach (rxc[i]) begin
			wr(rsc_pkg::ADDR_SYNC_HI, rxc[i][36:29]);
			wr(rsc_pkg::ADDR_SYNC_LO, rxc[i][28:21]);
			seen = 1'b0;
			for (int k = 0; k < 5; k++) begin
				@(posedge ref_clk);
				rx_symbol <= rxc[i][k*4+1 +: 4];
				rx_symbol_valid <= 1'b1;
				@(posedge ref_clk);
				rx_symbol_valid <= 1'b0;
				repeat (3) begin
					@(posedge ref_clk);
					#1;
					if (frame_sync_found === 1'b1) begin
						seen = 1'b1;
					end
				end
			end
			chk_bit("frame sync found", rxc[i][0], seen);
		end
		$display("test receive done");
		repeat (40) begin
			@(posedge ref_clk);
			rx_sample_valid <= 1'b1;
			@(posedge ref_clk);
			rx_sample_valid <= 1'b0;
			repeat (98) @(posedge ref_clk);
		end
		rd(rsc_pkg::ADDR_RSSI, q);
		chk8("signal strength", 8'hEC, q);
		chk_bit("channel clear", 1'b0, channel_clear_indication);
		wr(rsc_pkg::ADDR_CHANNEL_CLEAR_THRESHOLD, 8'hF0);
		wr(rsc_pkg::ADDR_RSSI, 8'h55);
		rd(rsc_pkg::ADDR_RSSI, q);
		chk8("strength after write", 8'hEC, q);
		chk_bit("channel clear", 1'b1, channel_clear_indication);
		$display("test signal strength done");
		give_verdict();
	end

	// Tests need about 13000 cycles; give them close to three times that
	initial begin
		#(50 * 40000);
		num_errors++;
		give_verdict();
	end
endmodule
